// ---- rwd_watchdog.sv ----
// runaway watchdog sharing its binary counter chain with the warm-up timer
// assumes a one-cycle register port and synchronous halt and wake strobes
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module rwd_watchdog (
    input wire logic mclk_in,                 // system clock, 100 MHz
    input wire logic reset_n_in,              // async reset, active low
    input wire logic [7:0] addr_in,           // register byte address
    input wire logic [7:0] wr_data_in,        // register write data
    input wire logic wr_en_in,                // write strobe
    input wire logic rd_en_in,                // read strobe
    output logic [7:0] rd_data_out,           // read data, cycle after strobe
    input wire logic halt_req_in,             // halt instruction executed
    input wire logic wake_in,                 // interrupt that ends a halt
    output logic runaway_nmi_out,             // watchdog nmi pulse
    output logic wdt_reset_out,               // internal reset pulse
    output logic cpu_halt_out,                // processor held in standby
    output logic osc_stop_out,                // oscillator stopped
    output logic stop_pin_drive_out           // keep output pins driven in stop
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic qcu_ff;
    logic active_ff;
    logic nmi_ff;
    logic wdrst_ff;
    logic [7:0] rd_data_ff;
    rwd_pkg::rwd_state_t state_ff;
    rwd_pkg::rwd_state_t nxt_state;
    logic soft_rst;
    logic wr_mode;
    logic wr_cmd;
    logic wr_tpc;
    logic cmd_clear;
    logic cmd_disable;
    logic chain_clear;
    logic chain_en;
    logic pre_carry;
    logic [rwd_pkg::PRE_STAGES-1:0] pre_count;
    logic [rwd_pkg::MAIN_STAGES-1:0] main_count;
    logic [rwd_pkg::CHAIN_W-1:0] chain;
    logic [1:0] period_sel;
    logic [1:0] halt_sel;
    logic tap_hit;
    logic warm_hit;
    logic overflow;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign wr_mode = wr_en_in && (addr_in == rwd_pkg::MODE_OFS);
    assign wr_cmd = wr_en_in && (addr_in == rwd_pkg::CMD_OFS);
    assign wr_tpc = wr_en_in && (addr_in == rwd_pkg::TPC_OFS);
    // only two codes act; anything else on the command register is dropped
    assign cmd_clear = wr_cmd && (wr_data_in == rwd_pkg::CMD_CLEAR);
    assign cmd_disable = wr_cmd && (wr_data_in == rwd_pkg::CMD_DISABLE);

    assign period_sel = mode_ff[rwd_pkg::MODE_PER_LSB +: 2];
    assign halt_sel = {mode_ff[rwd_pkg::MODE_HALT_HI_BIT], mode_ff[rwd_pkg::MODE_HALT_LO_BIT]};

    // a routed overflow resets all state here but the read data one cycle later
    assign soft_rst = wdrst_ff;

    // ------------------------------------------------------------------
    // tap helper
    // ------------------------------------------------------------------
    // true when the low n bits of the chain are all ones, so the next
    // step carries out of bit n-1, i.e. the 2^n output overflows
    function automatic logic low_bits_full(input logic [rwd_pkg::CHAIN_W-1:0] value,
                                           input int n);
        logic [rwd_pkg::CHAIN_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < rwd_pkg::CHAIN_W; i++) begin
            if (i < n) begin
                mask[i] = 1'b1;
            end
        end
        return &(value | ~mask);
    endfunction

    // ------------------------------------------------------------------
    // shared counter chain
    // ------------------------------------------------------------------
    // frozen while the processor sleeps in idle1 or stop, running in warm-up,
    // and in every other state while enabled, as right after reset release
    always_comb begin
        case (state_ff)
            rwd_pkg::RWD_IDLE1: chain_en = 1'b0;
            rwd_pkg::RWD_STOP: chain_en = 1'b0;
            rwd_pkg::RWD_WARM: chain_en = 1'b1;
            default: chain_en = active_ff;
        endcase
    end

    // zeroed by the clear code, on stop release, and by a routed reset
    assign chain_clear = cmd_clear || soft_rst
                         || (state_ff == rwd_pkg::RWD_STOP && wake_in);

    rwd_bin_counter #(
        .WIDTH(rwd_pkg::PRE_STAGES)
    ) u_pre (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .clear_in(chain_clear),
        .count_en_in(chain_en),
        .count_out(pre_count),
        .carry_out(pre_carry)
    );

    // main stage steps once per prescaler wrap
    rwd_bin_counter #(
        .WIDTH(rwd_pkg::MAIN_STAGES)
    ) u_main (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .clear_in(chain_clear),
        .count_en_in(pre_carry),
        .count_out(main_count),
        .carry_out()
    );

    assign chain = {main_count, pre_count};

    // ------------------------------------------------------------------
    // period tap and warm-up tap
    // ------------------------------------------------------------------
    always_comb begin
        case (period_sel)
            2'b00: tap_hit = low_bits_full(chain, rwd_pkg::TAP_P0);
            2'b01: tap_hit = low_bits_full(chain, rwd_pkg::TAP_P1);
            2'b10: tap_hit = low_bits_full(chain, rwd_pkg::TAP_P2);
            2'b11: tap_hit = low_bits_full(chain, rwd_pkg::TAP_P3);
            default: tap_hit = 1'b0;
        endcase
    end

    // quick warm-up wins over the warm select bit
    always_comb begin
        if (qcu_ff) begin
            warm_hit = low_bits_full(chain, rwd_pkg::WARM_QUICK);
        end else if (mode_ff[rwd_pkg::MODE_WARM_BIT]) begin
            warm_hit = low_bits_full(chain, rwd_pkg::WARM_LONG);
        end else begin
            warm_hit = low_bits_full(chain, rwd_pkg::WARM_SHORT);
        end
    end

    // overflow only counts outside warm-up; a clear in the same cycle
    // still lets the pending overflow through, it was already due
    assign overflow = chain_en && tap_hit && active_ff
                      && (state_ff != rwd_pkg::RWD_WARM);

    // ------------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------------
    always_comb begin
        nxt_mode = mode_ff;
        if (wr_mode) begin
            nxt_mode = wr_data_in;
        end
    end

    // reset value: enabled, period 00, reset route 0, pin drive 0
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_ff <= rwd_pkg::MODE_RST;
        end else if (soft_rst) begin
            mode_ff <= rwd_pkg::MODE_RST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------------
    // enable state
    // ------------------------------------------------------------------
    // clearing the bit alone keeps it running; the disable code must
    // follow, which makes a runaway stop of the watchdog unlikely
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_ff <= 1'b1;
        end else if (soft_rst) begin
            active_ff <= 1'b1;
        end else if (wr_mode && wr_data_in[rwd_pkg::MODE_EN_BIT]) begin
            active_ff <= 1'b1;
        end else if (cmd_disable && !mode_ff[rwd_pkg::MODE_EN_BIT]) begin
            active_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // timer pair control, quick warm-up bit
    // ------------------------------------------------------------------
    // forced low while the watchdog runs, the quick warm-up is lost then
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            qcu_ff <= rwd_pkg::TPC_RST[rwd_pkg::TPC_QCU_BIT];
        end else if (soft_rst || active_ff) begin
            qcu_ff <= 1'b0;
        end else if (wr_tpc) begin
            qcu_ff <= wr_data_in[rwd_pkg::TPC_QCU_BIT];
        end
    end

    // ------------------------------------------------------------------
    // nmi and routed reset pulses
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nmi_ff <= 1'b0;
        end else begin
            nmi_ff <= overflow && !soft_rst;
        end
    end

    // the route bit decides whether an overflow also resets the device
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wdrst_ff <= 1'b0;
        end else begin
            wdrst_ff <= overflow && !soft_rst
                        && mode_ff[rwd_pkg::MODE_RESET_ROUTE_BIT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // standby sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rwd_pkg::RWD_RUN: begin
                if (halt_req_in) begin
                    case (halt_sel)
                        rwd_pkg::HALT_STOP: nxt_state = rwd_pkg::RWD_STOP;
                        rwd_pkg::HALT_IDLE1: nxt_state = rwd_pkg::RWD_IDLE1;
                        rwd_pkg::HALT_IDLE2: nxt_state = rwd_pkg::RWD_IDLE2;
                        default: nxt_state = rwd_pkg::RWD_HOLD;
                    endcase
                end
            end
            rwd_pkg::RWD_HOLD,
            rwd_pkg::RWD_IDLE1,
            rwd_pkg::RWD_IDLE2: begin
                if (wake_in) begin
                    nxt_state = rwd_pkg::RWD_RUN;
                end
            end
            // oscillator restarts; wait the warm-up before running again
            rwd_pkg::RWD_STOP: begin
                if (wake_in) begin
                    nxt_state = rwd_pkg::RWD_WARM;
                end
            end
            rwd_pkg::RWD_WARM: begin
                if (warm_hit) begin
                    nxt_state = rwd_pkg::RWD_RUN;
                end
            end
            default: nxt_state = rwd_pkg::RWD_RUN;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= rwd_pkg::RWD_RUN;
        end else if (soft_rst) begin
            state_ff <= rwd_pkg::RWD_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // command register reads zero; unmapped addresses read zero
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_ff <= 8'h00;
        end else if (rd_en_in) begin
            case (addr_in)
                rwd_pkg::MODE_OFS: rd_data_ff <= mode_ff;
                rwd_pkg::TPC_OFS: rd_data_ff <= {7'h00, qcu_ff};
                rwd_pkg::STAT_OFS: begin
                    rd_data_ff <= 8'h00;
                    rd_data_ff[rwd_pkg::STAT_ACT_BIT] <= active_ff;
                    rd_data_ff[rwd_pkg::STAT_WARM_BIT] <= (state_ff == rwd_pkg::RWD_WARM);
                    rd_data_ff[rwd_pkg::STAT_HALT_BIT] <= cpu_halt_out;
                    rd_data_ff[rwd_pkg::STAT_STOP_BIT] <= (state_ff == rwd_pkg::RWD_STOP);
                end
                default: rd_data_ff <= 8'h00;
            endcase
        end else begin
            rd_data_ff <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data_out = rd_data_ff;
    assign runaway_nmi_out = nmi_ff;
    assign wdt_reset_out = wdrst_ff;
    assign cpu_halt_out = (state_ff != rwd_pkg::RWD_RUN);
    assign osc_stop_out = (state_ff == rwd_pkg::RWD_STOP);
    assign stop_pin_drive_out = osc_stop_out && mode_ff[rwd_pkg::MODE_STOP_PIN_DRIVE_BIT];
endmodule

// ---- rwd_pkg.sv ----
// package for the runaway watchdog and warm-up timer
// assumes one system clock that also drives the shared binary counters
package rwd_pkg;

    // ------------------------------------------------------------------
    // register map, byte offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_OFS = 8'h5C;     // watchdog_mode_control
    localparam logic [7:0] CMD_OFS = 8'h5D;      // watchdog_command_reg, write only
    localparam logic [7:0] TPC_OFS = 8'h5E;      // timer_pair_control
    localparam logic [7:0] STAT_OFS = 8'h5F;     // status, read only

    // ------------------------------------------------------------------
    // mode register fields and reset value
    // ------------------------------------------------------------------
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_PER_LSB = 5;
    localparam int MODE_WARM_BIT = 4;
    localparam int MODE_HALT_HI_BIT = 3;
    localparam int MODE_HALT_LO_BIT = 2;
    localparam int MODE_RESET_ROUTE_BIT_BIT = 1;
    localparam int MODE_STOP_PIN_DRIVE_BIT = 0;
    localparam logic [7:0] MODE_RST = 8'h80;     // enabled, shortest period, rest 0

    // timer pair control: quick warm-up bit
    localparam int TPC_QCU_BIT = 0;
    localparam logic [7:0] TPC_RST = 8'h00;

    // status fields
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_WARM_BIT = 1;
    localparam int STAT_HALT_BIT = 2;
    localparam int STAT_STOP_BIT = 3;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR = 8'h4E;
    localparam logic [7:0] CMD_DISABLE = 8'hB1;

    // ------------------------------------------------------------------
    // counter chain and tap positions, in bits of the whole chain
    // ------------------------------------------------------------------
    localparam int PRE_STAGES = 7;
    localparam int MAIN_STAGES = 15;
    localparam int CHAIN_W = PRE_STAGES + MAIN_STAGES;
    localparam int TAP_P0 = 15;                  // system_clock / 2^15
    localparam int TAP_P1 = 17;
    localparam int TAP_P2 = 19;
    localparam int TAP_P3 = 21;
    localparam int WARM_SHORT = PRE_STAGES + 7;  // 2^7 output of main stage
    localparam int WARM_LONG = PRE_STAGES + 9;   // 2^9 output of main stage
    localparam int WARM_QUICK = 7;               // 2^7 count

    // standby mode codes in the mode register
    localparam logic [1:0] HALT_RUN = 2'b00;
    localparam logic [1:0] HALT_STOP = 2'b01;
    localparam logic [1:0] HALT_IDLE1 = 2'b10;
    localparam logic [1:0] HALT_IDLE2 = 2'b11;

    typedef enum logic [2:0] {
        RWD_RUN,
        RWD_HOLD,
        RWD_IDLE1,
        RWD_IDLE2,
        RWD_STOP,
        RWD_WARM
    } rwd_state_t;

endpackage

// ---- rwd_bin_counter.sv ----
// one stage group of the shared binary counter chain
// assumes clear and enable are synchronous to mclk_in
`timescale 1ns/1ps
module rwd_bin_counter #(
    parameter int WIDTH = 7
) (
    input wire logic mclk_in,                 // system clock
    input wire logic reset_n_in,              // async reset, active low
    input wire logic clear_in,                // synchronous zero
    input wire logic count_en_in,             // advance one step
    output logic [WIDTH-1:0] count_out,       // current count
    output logic carry_out                    // wraps on this step
);

    logic [WIDTH-1:0] count_ff;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // clear beats advance so a clear never leaves a stale step behind
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_ff <= '0;
        end else if (clear_in) begin
            count_ff <= '0;
        end else if (count_en_in) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign count_out = count_ff;
    assign carry_out = count_en_in && (&count_ff); // carry into next group
endmodule

// ---- rwd_watchdog_checker.sv ----
// assertions on the ports of the runaway watchdog
// assumes it is bound onto rwd_watchdog, one clock, async active-low reset
`timescale 1ns/1ps
module rwd_watchdog_checker (
    input wire logic mclk_in,              // system clock
    input wire logic reset_n_in,           // async reset, active low
    input wire logic [7:0] addr_in,        // register address
    input wire logic [7:0] wr_data_in,     // write data
    input wire logic wr_en_in,             // write strobe
    input wire logic rd_en_in,             // read strobe
    input wire logic [7:0] rd_data_out,    // read data
    input wire logic halt_req_in,          // halt request
    input wire logic wake_in,              // wake pulse
    input wire logic runaway_nmi_out,      // nmi pulse
    input wire logic wdt_reset_out,        // routed reset pulse
    input wire logic cpu_halt_out,         // standby flag
    input wire logic osc_stop_out,         // oscillator stopped
    input wire logic stop_pin_drive_out    // pins kept driven
);
    // ------------------------------------------------------------------
    // helper: cycles since the last clear code or reset
    // ------------------------------------------------------------------
    logic clr_wr;
    logic [21:0] since_clr_ff;
    assign clr_wr = wr_en_in && (addr_in == rwd_pkg::CMD_OFS)
        && (wr_data_in == rwd_pkg::CMD_CLEAR);
    // saturates so a long quiet stretch never wraps back to a small count
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            since_clr_ff <= 22'h000000;
        end else if (clr_wr || wdt_reset_out) begin
            since_clr_ff <= 22'h000000;
        end else if (since_clr_ff != 22'h3FFFFF) begin
            since_clr_ff <= since_clr_ff + 22'h000001;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_nmi_pulse; runaway_nmi_out |=> !runaway_nmi_out; endproperty
    a_nmi_pulse: assert property (p_nmi_pulse)
        else $error("nmi held longer than one cycle");
    // overflow in the clear cycle itself still fires, so that cycle is exempt
    property p_nmi_min;
        runaway_nmi_out && !$past(clr_wr) |-> since_clr_ff >= 22'd32767;
    endproperty
    a_nmi_min: assert property (p_nmi_min)
        else $error("nmi sooner than the shortest period after a clear");
    property p_rst_with_nmi; wdt_reset_out |-> runaway_nmi_out; endproperty
    a_rst_with_nmi: assert property (p_rst_with_nmi)
        else $error("routed reset without an overflow");
    property p_rst_after; wdt_reset_out |=> !runaway_nmi_out && !cpu_halt_out; endproperty
    a_rst_after: assert property (p_rst_after)
        else $error("block not back in run after routed reset");
    property p_stop_drive; stop_pin_drive_out |-> osc_stop_out; endproperty
    a_stop_drive: assert property (p_stop_drive)
        else $error("pin drive outside stop");
    property p_halt_stop; osc_stop_out |-> cpu_halt_out; endproperty
    a_halt_stop: assert property (p_halt_stop)
        else $error("stop without processor halt");
    property p_wake; osc_stop_out && wake_in |=> (!osc_stop_out && cpu_halt_out) [*2]; endproperty
    a_wake: assert property (p_wake)
        else $error("stop release skipped the warm-up");
    property p_stop_quiet; osc_stop_out |-> !runaway_nmi_out; endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("overflow while stopped");
    property p_stop_enter; $rose(osc_stop_out) |-> $past(halt_req_in); endproperty
    a_stop_enter: assert property (p_stop_enter)
        else $error("stop entered without a halt request");
endmodule

bind rwd_watchdog rwd_watchdog_checker u_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .halt_req_in(halt_req_in), .wake_in(wake_in),
    .runaway_nmi_out(runaway_nmi_out), .wdt_reset_out(wdt_reset_out),
    .cpu_halt_out(cpu_halt_out), .osc_stop_out(osc_stop_out),
    .stop_pin_drive_out(stop_pin_drive_out));

// ---- testbench.sv ----
// self-checking bench for the runaway watchdog
// assumes the plain register port and no shortening parameters
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic halt_req_in = 1'b0;
    logic wake_in = 1'b0;
    logic [7:0] rd_data_out;
    logic runaway_nmi_out, wdt_reset_out, cpu_halt_out, osc_stop_out, stop_pin_drive_out;
    int n_fail = 0;
    int num_checks = 0;
    int first;
    logic rst_seen;

    rwd_watchdog u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .halt_req_in(halt_req_in), .wake_in(wake_in),
        .runaway_nmi_out(runaway_nmi_out), .wdt_reset_out(wdt_reset_out),
        .cpu_halt_out(cpu_halt_out), .osc_stop_out(osc_stop_out),
        .stop_pin_drive_out(stop_pin_drive_out));

    // ------------------------------------------------------------------
    // clock and bus helpers
    // ------------------------------------------------------------------
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        chk(what, rd_data_out, exp);
        @(posedge mclk_in);
    endtask
    // first cycle with the nmi high, 0 if none within n cycles
    task automatic watch(input int n);
        first = 0;
        rst_seen = 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(posedge mclk_in);
            #1;
            if (runaway_nmi_out === 1'b1 && first == 0) begin
                first = i;
                rst_seen = wdt_reset_out;
            end
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_after_reset;
        watch(32800);
        chk("first nmi", first, 32768);
        chk("reset pulse unrouted", rst_seen, 1'b0);
        rd(rwd_pkg::MODE_OFS, 8'h80, "mode reset");
        rd(rwd_pkg::TPC_OFS, 8'h00, "quick bit reset");
        rd(rwd_pkg::STAT_OFS, 8'h01, "status reset");
        rd(8'h40, 8'h00, "unmapped read");
    endtask
    // a clear pushes the pending overflow out past its old slot;
    // a stray code does not restart the count
    task automatic t_clear_route;
        wr(rwd_pkg::MODE_OFS, 8'h82);
        watch(100);
        wr(rwd_pkg::CMD_OFS, rwd_pkg::CMD_CLEAR);
        watch(32700);
        chk("nmi after clear", first, 0);
        wr(rwd_pkg::CMD_OFS, 8'h55);
        watch(100);
        chk("nmi after stray code", first, 67);
        chk("routed reset", rst_seen, 1'b1);
        rd(rwd_pkg::MODE_OFS, 8'h80, "mode after routed reset");
    endtask
    // counter parked just short of the shortest tap, so a short watch
    // shows the disable; keeps the run about 11000 cycles inside the 110000-cycle budget
    task automatic t_disable;
        wr(rwd_pkg::CMD_OFS, rwd_pkg::CMD_DISABLE);
        rd(rwd_pkg::STAT_OFS, 8'h01, "disable while enabled");
        wr(rwd_pkg::TPC_OFS, 8'h01);
        rd(rwd_pkg::TPC_OFS, 8'h00, "quick bit while active");
        wr(rwd_pkg::CMD_OFS, rwd_pkg::CMD_CLEAR);
        watch(32600);
        wr(rwd_pkg::MODE_OFS, 8'h00);
        rd(rwd_pkg::STAT_OFS, 8'h01, "enable bit alone");
        wr(rwd_pkg::CMD_OFS, rwd_pkg::CMD_DISABLE);
        rd(rwd_pkg::STAT_OFS, 8'h00, "disabled");
        watch(300);
        chk("nmi while disabled", first, 0);
        wr(rwd_pkg::TPC_OFS, 8'h01);
        rd(rwd_pkg::TPC_OFS, 8'h01, "quick bit while disabled");
    endtask
    // re-enabled on the longer period, the parked count crosses the
    // shortest tap with no nmi; then disabled again for the stop test
    task automatic t_period;
        wr(rwd_pkg::MODE_OFS, 8'hA0);
        rd(rwd_pkg::STAT_OFS, 8'h01, "re-enabled by bit");
        watch(300);
        chk("longer period", first, 0);
        wr(rwd_pkg::MODE_OFS, 8'h00);
        rd(rwd_pkg::TPC_OFS, 8'h00, "quick bit lost on enable");
        wr(rwd_pkg::CMD_OFS, rwd_pkg::CMD_DISABLE);
        rd(rwd_pkg::STAT_OFS, 8'h00, "disabled again");
        wr(rwd_pkg::TPC_OFS, 8'h01);
        @(posedge mclk_in);
    endtask
    // quick warm-up wins over the long warm select
    task automatic t_stop;
        wr(rwd_pkg::MODE_OFS, 8'h15);
        halt_req_in <= 1'b1;
        @(posedge mclk_in);
        halt_req_in <= 1'b0;
        #1;
        chk("stop entered", {cpu_halt_out, osc_stop_out, stop_pin_drive_out}, 3'b111);
        repeat (4) @(posedge mclk_in);
        wake_in <= 1'b1;
        @(posedge mclk_in);
        wake_in <= 1'b0;
        #1;
        chk("warm-up entered", {cpu_halt_out, osc_stop_out}, 2'b10);
        first = 0;
        for (int i = 1; i <= 200 && first == 0; i++) begin
            @(posedge mclk_in);
            #1;
            if (cpu_halt_out === 1'b0) begin
                first = i;
            end
        end
        chk("quick warm-up length", first, 128);
        wr(rwd_pkg::MODE_OFS, 8'h80);
        rd(rwd_pkg::STAT_OFS, 8'h01, "re-enabled");
        rd(rwd_pkg::TPC_OFS, 8'h00, "quick bit cleared");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_after_reset();
        t_clear_route();
        t_disable();
        t_period();
        t_stop();
        wrap_up();
    end
    initial begin
        #1100000;
        n_fail++;
        wrap_up();
    end
endmodule
